// *** design/flash_erase_host.sv ***
// Purpose: Host controller issuing erase, suspend and resume sequences
// Assumes: Word mode; one user command at a time
// Notes: Reports window timing and suspend latency to the user
`timescale 1ns/100ps
`default_nettype none
module flash_erase_host #(
	parameter int GAP_CYCLES     = flash_erase_pkg::GAP_CYC,
	parameter int SUSPEND_CYCLES = flash_erase_pkg::SUSPEND_CYC
) (
	input  wire logic        I_CLK_SYS,
	input  wire logic        I_ARST_N,
	input  wire logic        I_CMD_VALID,
	input  wire logic [3:0]  I_CMD_OP,
	input  wire logic [19:0] I_CMD_ADDR,
	input  wire logic [15:0] I_CMD_DATA,
	input  wire logic [15:0] I_DQ,
	input  wire logic        I_READY_BUSY,
	output logic             O_CMD_READY,
	output logic             O_CMD_DONE,
	output logic [15:0]      O_RDATA,
	output logic             O_GAP_EXPIRED,
	output logic             O_SUSPEND_LATE,
	output logic             O_TIME_LIMIT,
	output logic             O_DEVICE_BUSY,
	output logic [19:0]      O_ADDR,
	output logic [15:0]      O_DQ,
	output logic             O_DQ_OE,
	output logic             O_CS_N,
	output logic             O_WE_N,
	output logic             O_OE_N
);
	typedef enum logic [1:0] {S_IDLE = 2'b00, S_ISSUE = 2'b01, S_WAIT = 2'b11} seq_state_e;

	flash_bus_if bus ();

	seq_state_e  state_ff;
	logic [2:0]  step_ff;
	logic [2:0]  len_ff;
	logic [3:0]  op_ff;
	logic [19:0] addr_ff;
	logic [15:0] data_ff;
	logic        req_ff;
	logic [15:0] gap_ff;
	logic        gap_run_ff;
	logic [15:0] susp_ff;
	logic        susp_run_ff;

	// Step table of one sequence: returns {addr, data}
	function automatic logic [35:0] seq_word(input logic [3:0] op, input logic [2:0] step,
			input logic [19:0] a, input logic [15:0] d);
		logic [35:0] w;
		w = {a, d};
		if (op == flash_erase_pkg::OP_CHIP || op == flash_erase_pkg::OP_SECTOR) begin
			case (step)
				3'h0, 3'h3: w = {flash_erase_pkg::UNLOCK_ADDR_1, flash_erase_pkg::UNLOCK_DATA_1};
				3'h1, 3'h4: w = {flash_erase_pkg::UNLOCK_ADDR_2, flash_erase_pkg::UNLOCK_DATA_2};
				3'h2:       w = {flash_erase_pkg::UNLOCK_ADDR_1, flash_erase_pkg::CMD_SETUP};
				default:    w = (op == flash_erase_pkg::OP_CHIP) ?
					{flash_erase_pkg::UNLOCK_ADDR_1, flash_erase_pkg::CMD_CHIP} :
					{a, flash_erase_pkg::CMD_SECTOR};
			endcase
		end else if (op == flash_erase_pkg::OP_ADD_SECTOR) begin
			w = {a, flash_erase_pkg::CMD_SECTOR};
		end else if (op == flash_erase_pkg::OP_SUSPEND) begin
			w = {20'h00000, flash_erase_pkg::CMD_SUSPEND};
		end else if (op == flash_erase_pkg::OP_RESUME) begin
			w = {20'h00000, flash_erase_pkg::CMD_RESUME};
		end else if (op == flash_erase_pkg::OP_RESET) begin
			w = {20'h00000, flash_erase_pkg::CMD_RESET};
		end
		return w;
	endfunction

	function automatic logic [2:0] seq_len(input logic [3:0] op);
		// Both erase kinds are six writes
		if (op == flash_erase_pkg::OP_CHIP || op == flash_erase_pkg::OP_SECTOR)
			return 3'h6;
		return 3'h1;
	endfunction

	flash_bus_cycle u_cycle (
		.i_clk   (I_CLK_SYS),
		.i_arst_n(I_ARST_N),
		.bus     (bus),
		.i_dq    (I_DQ),
		.o_addr  (O_ADDR),
		.o_dq    (O_DQ),
		.o_dq_oe (O_DQ_OE),
		.o_cs_n  (O_CS_N),
		.o_we_n  (O_WE_N),
		.o_oe_n  (O_OE_N)
	);

	logic [35:0] cur_word;
	assign cur_word  = seq_word(op_ff, step_ff, addr_ff, data_ff);
	assign bus.req   = req_ff;
	assign bus.wr    = (op_ff != flash_erase_pkg::OP_READ);
	assign bus.addr  = cur_word[35:16];
	assign bus.wdata = cur_word[15:0];

	logic last_done;
	assign last_done = bus.done && (step_ff == len_ff - 3'h1);

	// Sequencer; the device keeps its own erase algorithm
	always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			state_ff    <= S_IDLE;
			step_ff     <= 3'h0;
			len_ff      <= 3'h1;
			op_ff       <= 4'h0;
			addr_ff     <= 20'h00000;
			data_ff     <= 16'h0000;
			req_ff      <= 1'b0;
			O_CMD_READY <= 1'b0;
			O_CMD_DONE  <= 1'b0;
			O_RDATA     <= 16'h0000;
		end else begin
			O_CMD_DONE <= 1'b0;
			case (state_ff)
				S_IDLE: begin
					O_CMD_READY <= 1'b1;
					if (I_CMD_VALID && O_CMD_READY) begin
						O_CMD_READY <= 1'b0;
						op_ff       <= I_CMD_OP;
						addr_ff     <= I_CMD_ADDR;
						data_ff     <= I_CMD_DATA;
						len_ff      <= seq_len(I_CMD_OP);
						// Each erase restarts from the first unlock write
						step_ff     <= 3'h0;
						req_ff      <= 1'b1;
						state_ff    <= S_ISSUE;
					end
				end
				S_ISSUE: begin
					req_ff   <= 1'b0;
					state_ff <= S_WAIT;
				end
				S_WAIT: begin
					if (last_done) begin
						O_RDATA    <= bus.rdata;
						O_CMD_DONE <= 1'b1;
						state_ff   <= S_IDLE;
					end else if (bus.done) begin
						step_ff  <= step_ff + 3'h1;
						req_ff   <= 1'b1;
						state_ff <= S_ISSUE;
					end
				end
				default: state_ff <= S_IDLE;
			endcase
		end
	end

	// Gap since the last sector write, from its strobe rise
	always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			gap_ff        <= 16'h0000;
			gap_run_ff    <= 1'b0;
			O_GAP_EXPIRED <= 1'b0;
		end else if (last_done && (op_ff == flash_erase_pkg::OP_SECTOR ||
				op_ff == flash_erase_pkg::OP_ADD_SECTOR)) begin
			// Strobe rose one hold phase before done
			gap_ff        <= 16'(flash_erase_pkg::PHASE_CYC + 1);
			gap_run_ff    <= 1'b1;
			O_GAP_EXPIRED <= 1'b0;
		end else if (last_done && op_ff != flash_erase_pkg::OP_READ) begin
			// Suspend, reset or stray write ends the window
			if (gap_run_ff) begin
				O_GAP_EXPIRED <= 1'b1;
			end
			gap_run_ff <= 1'b0;
		end else if (gap_run_ff) begin
			// Reads leave an open window running
			if (gap_ff >= 16'(GAP_CYCLES)) begin
				// Later sector writes may be refused by the device
				O_GAP_EXPIRED <= 1'b1;
				gap_run_ff    <= 1'b0;
			end else begin
				gap_ff <= gap_ff + 16'h0001;
			end
		end
	end

	// Suspend latency watch on the ready/busy line
	always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			susp_ff        <= 16'h0000;
			susp_run_ff    <= 1'b0;
			O_SUSPEND_LATE <= 1'b0;
		end else if (last_done && op_ff == flash_erase_pkg::OP_SUSPEND) begin
			// Latency counts from the strobe rise, not from done
			susp_ff        <= 16'(flash_erase_pkg::PHASE_CYC + 1);
			susp_run_ff    <= 1'b1;
			O_SUSPEND_LATE <= 1'b0;
		end else if (susp_run_ff) begin
			if (I_READY_BUSY) begin
				susp_run_ff <= 1'b0;
			end else if (susp_ff >= 16'(SUSPEND_CYCLES)) begin
				O_SUSPEND_LATE <= 1'b1;
				susp_run_ff    <= 1'b0;
			end else begin
				susp_ff <= susp_ff + 16'h0001;
			end
		end
	end

	// Status from reads and ready/busy pin
	always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			O_TIME_LIMIT  <= 1'b0;
			O_DEVICE_BUSY <= 1'b0;
		end else begin
			O_DEVICE_BUSY <= !I_READY_BUSY;
			if (last_done && op_ff == flash_erase_pkg::OP_READ) begin
				O_TIME_LIMIT <= bus.rdata[flash_erase_pkg::TLIMIT_BIT];
			end else if (last_done && op_ff == flash_erase_pkg::OP_RESET) begin
				O_TIME_LIMIT <= 1'b0;
			end
		end
	end
endmodule
`default_nettype wire

// *** design/flash_erase_pkg.sv ***
// Purpose: Constants for the host-side flash erase sequencer
// Assumes: Word-mode command set, 50 MHz system clock
// Notes: Word-mode command codes and cycle counts
// Contract
// - Chip erase is six writes
// - Hardware reset aborts chip erase; reissue
// - Sector erase is six writes
// - Extra sectors queued under 50 us apart
// - Other writes in window abort sequence
// - Host keeps queuing gaps short; this host does not pace them, it raises O_GAP_EXPIRED after GAP_CYCLES
// - Hardware reset aborts sector erase; reissue
// - Resume continues erase; repeats ignored
// - Time limit bit requires reset command
`default_nettype none
package flash_erase_pkg;
	localparam int          ADDR_W        = 20;
	localparam int          DATA_W        = 16;
	localparam logic [19:0] UNLOCK_ADDR_1 = 20'h00555;
	localparam logic [19:0] UNLOCK_ADDR_2 = 20'h002AA;
	localparam logic [15:0] UNLOCK_DATA_1 = 16'h00AA;
	localparam logic [15:0] UNLOCK_DATA_2 = 16'h0055;
	localparam logic [15:0] CMD_SETUP     = 16'h0080;
	localparam logic [15:0] CMD_CHIP      = 16'h0010;
	localparam logic [15:0] CMD_SECTOR    = 16'h0030;
	localparam logic [15:0] CMD_SUSPEND   = 16'h00B0;
	localparam logic [15:0] CMD_RESUME    = 16'h0030;
	localparam logic [15:0] CMD_RESET     = 16'h00F0;
	// Status bit positions on the low data byte
	localparam int          POLL_BIT      = 7;
	localparam int          TOGGLE_BIT    = 6;
	localparam int          TLIMIT_BIT    = 5;
	localparam int          TIMER_BIT     = 3;
	localparam int          STOGGLE_BIT   = 2;
	localparam int          CLK_MHZ       = 50;
	localparam int          WINDOW_US     = 50;
	localparam int          SUSPEND_US    = 20;
	// Gap limit rounds down, suspend wait rounds up
	localparam int          GAP_CYC       = WINDOW_US * CLK_MHZ - 1;
	localparam int          SUSPEND_CYC   = SUSPEND_US * CLK_MHZ;
	// Bus strobe phases, each held this many cycles
	localparam int          PHASE_CYC     = 4;
	localparam logic [3:0]  OP_CHIP       = 4'h1;
	localparam logic [3:0]  OP_SECTOR     = 4'h2;
	localparam logic [3:0]  OP_ADD_SECTOR = 4'h3;
	localparam logic [3:0]  OP_SUSPEND    = 4'h4;
	localparam logic [3:0]  OP_RESUME     = 4'h5;
	localparam logic [3:0]  OP_RESET      = 4'h6;
	localparam logic [3:0]  OP_READ       = 4'h7;
	localparam logic [3:0]  OP_WRITE      = 4'h8;
endpackage
`default_nettype wire

// *** design/flash_bus_if.sv ***
// Purpose: Link between sequencer and bus cycle engine
// Assumes: Single clock
// Notes: One request at a time
`timescale 1ns/100ps
`default_nettype none
interface flash_bus_if;
	logic        req;
	logic        wr;
	logic [19:0] addr;
	logic [15:0] wdata;
	logic        done;
	logic [15:0] rdata;
	modport master (output req, output wr, output addr, output wdata, input done, input rdata);
	modport engine (input req, input wr, input addr, input wdata, output done, output rdata);
endinterface
`default_nettype wire

// *** design/flash_bus_cycle.sv ***
// Purpose: One asynchronous flash bus read or write cycle
// Assumes: Flash data pins sampled synchronously
// Notes: Chip select falls with write strobe; data latched on rise
`timescale 1ns/100ps
`default_nettype none
module flash_bus_cycle (
	input  wire logic        i_clk,
	input  wire logic        i_arst_n,
	flash_bus_if.engine      bus,
	input  wire logic [15:0] i_dq,
	output logic [19:0]      o_addr,
	output logic [15:0]      o_dq,
	output logic             o_dq_oe,
	output logic             o_cs_n,
	output logic             o_we_n,
	output logic             o_oe_n
);
	typedef enum logic [1:0] {B_IDLE = 2'b00, B_SETUP = 2'b01, B_STROBE = 2'b11, B_HOLD = 2'b10}
		bus_state_e;
	bus_state_e  state_ff;
	logic [2:0]  cnt_ff;
	logic        wr_ff;
	logic        done_ff;
	logic [15:0] rdata_ff;

	assign bus.done  = done_ff;
	assign bus.rdata = rdata_ff;

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			state_ff <= B_IDLE;
			cnt_ff   <= 3'h0;
			wr_ff    <= 1'b0;
			done_ff  <= 1'b0;
			rdata_ff <= 16'h0000;
			o_addr   <= 20'h00000;
			o_dq     <= 16'h0000;
			o_dq_oe  <= 1'b0;
			o_cs_n   <= 1'b1;
			o_we_n   <= 1'b1;
			o_oe_n   <= 1'b1;
		end else begin
			done_ff <= 1'b0;
			case (state_ff)
				B_IDLE: begin
					if (bus.req) begin
						// Address settles before the later falling strobe
						o_addr   <= bus.addr;
						o_dq     <= bus.wdata;
						o_dq_oe  <= bus.wr;
						wr_ff    <= bus.wr;
						cnt_ff   <= 3'(flash_erase_pkg::PHASE_CYC - 1);
						state_ff <= B_SETUP;
					end
				end
				B_SETUP: begin
					if (cnt_ff == 3'h0) begin
						o_cs_n   <= 1'b0;
						o_we_n   <= !wr_ff;
						o_oe_n   <= wr_ff;
						cnt_ff   <= 3'(flash_erase_pkg::PHASE_CYC - 1);
						state_ff <= B_STROBE;
					end else begin
						cnt_ff <= cnt_ff - 3'h1;
					end
				end
				B_STROBE: begin
					if (cnt_ff == 3'h0) begin
						// Write strobe rises first, data still driven
						o_we_n   <= 1'b1;
						o_oe_n   <= 1'b1;
						rdata_ff <= i_dq;
						cnt_ff   <= 3'(flash_erase_pkg::PHASE_CYC - 1);
						state_ff <= B_HOLD;
					end else begin
						cnt_ff <= cnt_ff - 3'h1;
					end
				end
				B_HOLD: begin
					o_cs_n <= 1'b1;
					if (cnt_ff == 3'h0) begin
						o_dq_oe  <= 1'b0;
						done_ff  <= 1'b1;
						state_ff <= B_IDLE;
					end else begin
						cnt_ff <= cnt_ff - 3'h1;
					end
				end
				default: state_ff <= B_IDLE;
			endcase
		end
	end
endmodule
`default_nettype wire

// *** dv/flash_erase_host_asserts.sv ***
// Purpose: Pin and handshake checks for the erase host
// Assumes: Ports of flash_erase_host only
// Notes: Strobe lengths follow the four-cycle phases
`timescale 1ns/100ps
`default_nettype none
module flash_erase_host_asserts (
	input wire logic        I_CLK_SYS,
	input wire logic        I_ARST_N,
	input wire logic        I_CMD_VALID,
	input wire logic        I_READY_BUSY,
	input wire logic        O_CMD_READY,
	input wire logic        O_CMD_DONE,
	input wire logic        O_DEVICE_BUSY,
	input wire logic [19:0] O_ADDR,
	input wire logic [15:0] O_DQ,
	input wire logic        O_DQ_OE,
	input wire logic        O_CS_N,
	input wire logic        O_WE_N,
	input wire logic        O_OE_N
);
	default clocking @(posedge I_CLK_SYS); endclocking
	default disable iff (!I_ARST_N);
	we_cs_a: assert property (!O_WE_N |-> !O_CS_N)
		else $error("write strobe without chip select");
	we_oe_a: assert property (!O_WE_N |-> O_OE_N && O_DQ_OE)
		else $error("write strobe with read enable or data released");
	we_len_a: assert property ($fell(O_WE_N) |-> !O_WE_N [*4] ##1 O_WE_N)
		else $error("write strobe length wrong");
	wr_hold_a: assert property (!O_WE_N && !$fell(O_WE_N) |-> $stable(O_ADDR) && $stable(O_DQ))
		else $error("address or data moved under write strobe");
	rd_dir_a: assert property (!O_OE_N |-> O_WE_N && !O_DQ_OE && !O_CS_N)
		else $error("read strobe while driving data");
	busy_set_a: assert property ($fell(I_READY_BUSY) |=> O_DEVICE_BUSY)
		else $error("busy not reported");
	busy_clr_a: assert property ($rose(I_READY_BUSY) |=> !O_DEVICE_BUSY)
		else $error("ready not reported");
	take_done_a: assert property (I_CMD_VALID && O_CMD_READY |=> !O_CMD_READY ##[10:200] O_CMD_DONE)
		else $error("request not completed in time");
	done_rdy_a: assert property (O_CMD_DONE |=> !O_CMD_DONE && O_CMD_READY)
		else $error("done pulse or ready return wrong");
endmodule
bind flash_erase_host flash_erase_host_asserts u_chk (.*);
`default_nettype wire

// *** dv/flash_erase_dev_model.sv ***
// Purpose: Behavioural erase side of the flash device
// Assumes: Times counted in system clock cycles
// Notes: Only the first queued sector is remembered
`timescale 1ns/100ps
`default_nettype none
module flash_erase_dev_model #(
	parameter int WIN_CYC   = 60,
	parameter int ERASE_CYC = 300,
	parameter int SUSP_CYC  = 10,
	// Arbitrary identification value
	parameter logic [15:0] ID_CODE = 16'h5A5A
) (
	input  wire logic        i_clk,
	input  wire logic [19:0] i_addr,
	input  wire logic [15:0] i_dq,
	input  wire logic        i_cs_n,
	input  wire logic        i_we_n,
	input  wire logic        i_oe_n,
	output logic [15:0]      o_dq,
	output logic             o_ready_busy
);
	typedef enum logic [2:0] {RD, WIN, ERS, CHIP, SUSP} mode_e;
	localparam logic [35:0] SEQ [5] = '{36'h00555_00AA, 36'h002AA_0055, 36'h00555_0080,
		36'h00555_00AA, 36'h002AA_0055};
	mode_e       mode  = RD;
	int          step  = 0;
	int          cnt   = 0;
	int          scnt  = 0;
	logic        armed = 1'b0;
	logic        tog   = 1'b0;
	logic [19:0] a_lat = '0;
	logic [4:0]  sect  = '0;
	logic [15:0] last  = '0;
	logic        idm   = 1'b0;
	assign o_ready_busy = mode == RD || mode == SUSP;
	// Released bus shows the inverse, never a stale match
	assign o_dq = (!i_cs_n && !i_oe_n) ? last : ~last;
	always @(negedge i_we_n or negedge i_cs_n) if (!i_we_n && !i_cs_n) begin
		a_lat = i_addr;
		armed = 1'b1;
	end
	always @(posedge i_we_n or posedge i_cs_n) if (armed) begin
		armed = 1'b0;
		case (mode)
		RD: if (step < 5) step = ({a_lat, i_dq} == SEQ[step]) ? step + 1 : 0;
			else begin
				if (i_dq == 16'h0010 && a_lat == 20'h00555) mode = CHIP;
				else if (i_dq == 16'h0030) mode = WIN;
				sect = a_lat[19:15];
				step = 0;
				cnt = 0;
			end
		WIN: if (i_dq == 16'h0030) cnt = 0;
			else mode = (i_dq == 16'h00B0) ? SUSP : RD;
		ERS: if (i_dq == 16'h00B0) scnt = SUSP_CYC;
		SUSP: if (i_dq == 16'h0030 && !idm) mode = ERS;
			else if (i_dq == 16'h0090 || i_dq == 16'h00F0) idm = (i_dq == 16'h0090);
		default: ;
		endcase
	end
	// Falling edge so ready/busy never races the host's sampling edge
	always @(negedge i_clk) begin
		if (mode != SUSP && mode != RD) cnt++;
		if (mode == WIN && cnt >= WIN_CYC) begin
			mode = ERS;
			cnt = 0;
		end
		if ((mode == ERS || mode == CHIP) && cnt >= ERASE_CYC) mode = RD;
		if (scnt > 0) begin
			scnt--;
			if (scnt == 0 && mode == ERS) mode = SUSP;
		end
	end
	always @(negedge i_oe_n or negedge i_cs_n) if (!i_oe_n && !i_cs_n) begin
		tog = ~tog;
		if (idm) last = ID_CODE;
		else if (mode == RD || (mode == SUSP && i_addr[19:15] != sect)) last = i_addr[15:0];
		else last = {8'h00, mode == SUSP, tog && mode != SUSP, 2'b00, mode != WIN, tog, 2'b00};
	end
endmodule
`default_nettype wire

// *** dv/test_flash_erase_host.sv ***
// Purpose: Self-checking bench for the erase host
// Assumes: Device model on the flash pins
// Notes: Short gap and suspend limits for run time
`timescale 1ns/100ps
`default_nettype none
module test_flash_erase_host;
	logic        clk = 1'b0, arst_n = 1'b0, valid = 1'b0;
	logic [3:0]  op = '0;
	logic [19:0] cmd_a = '0, pin_a;
	logic [15:0] cmd_d = '0, rdata, pin_d, dev_d;
	logic        rdy, done, gap_x, late, tlim, busy, dq_oe, cs_n, we_n, oe_n, rb;
	wire logic [15:0] dq = dq_oe ? pin_d : dev_d;
	logic [35:0] wq [$];
	int          fails = 0, check_count = 0;
	localparam logic [15:0] ID_CODE = 16'h5A5A; // Arbitrary identification value
	always #10 clk = ~clk;
	flash_erase_host #(.GAP_CYCLES(40), .SUSPEND_CYCLES(20)) i_dut (
		.I_CLK_SYS(clk), .I_ARST_N(arst_n), .I_CMD_VALID(valid), .I_CMD_OP(op),
		.I_CMD_ADDR(cmd_a), .I_CMD_DATA(cmd_d), .I_DQ(dq), .I_READY_BUSY(rb),
		.O_CMD_READY(rdy), .O_CMD_DONE(done), .O_RDATA(rdata), .O_GAP_EXPIRED(gap_x),
		.O_SUSPEND_LATE(late), .O_TIME_LIMIT(tlim), .O_DEVICE_BUSY(busy), .O_ADDR(pin_a),
		.O_DQ(pin_d), .O_DQ_OE(dq_oe), .O_CS_N(cs_n), .O_WE_N(we_n), .O_OE_N(oe_n));
	flash_erase_dev_model #(.ID_CODE(ID_CODE)) i_dev (.i_clk(clk), .i_addr(pin_a), .i_dq(dq), .i_cs_n(cs_n),
		.i_we_n(we_n), .i_oe_n(oe_n), .o_dq(dev_d), .o_ready_busy(rb));
	always @(posedge we_n) if (arst_n) wq.push_back({pin_a, pin_d});
	task automatic complete_run();
		if (fails == 0 && check_count > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [35:0] got, input logic [35:0] exp);
		check_count++;
		if (got !== exp) begin
			fails++;
			$display("mismatch %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic idle(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic cmd(input logic [3:0] o, input logic [19:0] a, input logic [15:0] d);
		int n;
		op = o;
		cmd_a = a;
		cmd_d = d;
		valid = 1'b1;
		while (rdy !== 1'b1) @(negedge clk);
		@(negedge clk);
		valid = 1'b0;
		for (n = 0; n < 200 && done !== 1'b1; n++) @(negedge clk);
		chk(done, 1'b1);
	endtask
	task automatic wait_busy(input logic v);
		int n;
		for (n = 0; n < 600 && busy !== v; n++) @(negedge clk);
		chk(busy, v);
	endtask
	task automatic seq(input logic [35:0] last);
		logic [35:0] exp [6];
		exp = '{36'h00555_00AA, 36'h002AA_0055, 36'h00555_0080, 36'h00555_00AA,
			36'h002AA_0055, last};
		chk(wq.size(), 6);
		foreach (exp[i]) chk(wq[i], exp[i]);
		wq.delete();
	endtask
	task automatic t_window();
		cmd(4'h2, 20'h18000, 16'h0000);
		seq({20'h18000, 16'h0030});
		idle(2);
		chk(busy, 1'b1);
		cmd(4'h3, 20'h20000, 16'h0000);
		chk(wq.pop_front(), {20'h20000, 16'h0030});
		chk(gap_x, 1'b0);
		cmd(4'h4, 20'h00000, 16'h0000);
		idle(2);
		chk({busy, late}, 2'b00);
		cmd(4'h7, 20'h18000, 16'h0000);
		chk(rdata[7], 1'b1);
		cmd(4'h7, 20'h00123, 16'h0000);
		chk(rdata, 16'h0123);
		cmd(4'h8, 20'h00555, 16'h0090);
		cmd(4'h7, 20'h18000, 16'h0000);
		chk(rdata, ID_CODE);
		cmd(4'h8, 20'h00000, 16'h00F0);
		cmd(4'h7, 20'h18000, 16'h0000);
		chk({rdata[7], busy}, 2'b10);
		cmd(4'h5, 20'h00000, 16'h0000);
		wait_busy(1'b1);
		wait_busy(1'b0);
		chk(gap_x, 1'b1);
		cmd(4'h7, 20'h18000, 16'h0000);
		chk(rdata, 16'h8000);
		wq.delete();
	endtask
	task automatic t_active();
		cmd(4'h2, 20'h08000, 16'h0000);
		idle(70);
		chk(gap_x, 1'b1);
		cmd(4'h8, 20'h00040, 16'h1234);
		chk(busy, 1'b1);
		cmd(4'h4, 20'h00000, 16'h0000);
		idle(12);
		chk({busy, late}, 2'b00);
		cmd(4'h5, 20'h00000, 16'h0000);
		cmd(4'h5, 20'h00000, 16'h0000);
		chk(busy, 1'b1);
		cmd(4'h4, 20'h00000, 16'h0000);
		idle(12);
		chk(busy, 1'b0);
		cmd(4'h5, 20'h00000, 16'h0000);
		wait_busy(1'b0);
		wq.delete();
	endtask
	task automatic t_chip();
		cmd(4'h1, 20'h00000, 16'h0000);
		seq({20'h00555, 16'h0010});
		cmd(4'h4, 20'h00000, 16'h0000);
		idle(30);
		chk(busy, 1'b1);
		chk(late, 1'b1);
		wait_busy(1'b0);
		cmd(4'h2, 20'h10000, 16'h0000);
		cmd(4'h8, 20'h00040, 16'h1234);
		idle(2);
		chk(busy, 1'b0);
		cmd(4'h7, 20'h00020, 16'h0000);
		chk(tlim, 1'b1);
		cmd(4'h6, 20'h00000, 16'h0000);
		chk(tlim, 1'b0);
		chk(wq[$], {20'h00000, 16'h00F0});
	endtask
	initial begin
		idle(8);
		arst_n = 1'b1;
		idle(2);
		t_window();
		t_active();
		t_chip();
		complete_run();
	end
	// Whole run is near 1500 cycles; thirteen times that means a hang
	initial begin
		#400000;
		fails++;
		complete_run();
	end
endmodule
`default_nettype wire
